// ==== logic/sfc_ctrl.sv ====
// Overview of operation
// - Lock-down protection returns to software mode on power-up
// - Quad enable turns protect and pause pins into data
// - Lock bits default zero, set once, never clear
// - Suspend sets erase or program paused flag
// - Resume, software reset, power-up clear paused flags
// - Two-bit field selects read drive strength
// - Shared pin is pause or reset unless quad
// - Reserved bits ignored; writing them has no effect
// - Program failure or protection sets program error
// - Erase failure or protection sets erase error
// - Clear-flag command clears both error flags
// - Address width status shows current address mode
// - Power-up width select sampled at initialisation and on software reset
// - Extended address register: bit zero only, rest reserved
// - Three-byte mode uses upper half select
// - Four-byte mode ignores, then overwrites, upper half select
// - Dedicated four-byte opcodes ignore extended address register; program and erase overwrite it
// - Bits sampled MSB first on rising serial clock
// - Register read commands shift data out until deselect
// - Write-class commands execute only on byte boundary
// - Partial page program byte: no program, latch kept
// - Cleared write latch refuses status write, program, erase
`timescale 1ns/10ps
`default_nettype none
module sfc_ctrl (
   // Clock and reset (reset models a power cycle)
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Serial link pins
   input wire logic cs_n_in,
   input wire logic sclk_in,
   input wire logic si_in,
   output logic so_out,
   output logic so_oe_out,
   // Array back end status
   input wire logic busy_erase_in,
   input wire logic busy_program_in,
   input wire logic program_fail_in,
   input wire logic erase_fail_in,
   input wire logic target_protected_in,
   input wire logic otp_locked_access_in,
   // Configuration outputs
   output logic quad_line_two_en_out,
   output logic quad_line_three_en_out,
   output logic pause_fn_en_out,
   output logic reset_fn_en_out,
   output logic [1:0] drive_strength_out,
   output logic [2:0] security_lock_out,
   output logic [1:0] protect_mode_out,
   // Command results to the array
   output logic program_start_out,
   output logic erase_start_out,
   output logic [31:0] array_addr_out,
   output logic write_latch_out
);
   // ==========================================
   // Pin synchronisers
   logic [1:0] cs_sync, sclk_sync, si_sync;
   logic sclk_d;
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cs_sync <= 2'h3;
         sclk_sync <= 2'h0;
         si_sync <= 2'h0;
         sclk_d <= 1'b0;
      end else begin
         cs_sync <= {cs_sync[0], cs_n_in};
         sclk_sync <= {sclk_sync[0], sclk_in};
         si_sync <= {si_sync[0], si_in};
         sclk_d <= sclk_sync[1];
      end
   end
   logic cs_n, sclk_rise, sclk_fall, si;
   logic cs_prev;
   assign cs_n = cs_sync[1];
   assign si = si_sync[1];
   assign sclk_rise = ~cs_n & sclk_sync[1] & ~sclk_d;
   assign sclk_fall = ~cs_n & ~sclk_sync[1] & sclk_d;
   logic cs_rise;
   assign cs_rise = cs_n & ~cs_prev;
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cs_prev <= 1'b1;
      end else begin
         cs_prev <= cs_n;
      end
   end
   // ==========================================
   // Bit and byte framing
   logic [2:0] bit_cnt;
   logic [7:0] shift_in;
   logic [7:0] opcode;
   logic [3:0] byte_cnt;
   logic have_op;
   logic byte_done;
   logic [7:0] next_byte;
   assign byte_done = sclk_rise && (bit_cnt == package_bit_last());
   assign next_byte = {shift_in[6:0], si};
   function automatic logic [2:0] package_bit_last();
      return sfc_pkg::BIT_CNT_LAST;
   endfunction
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         bit_cnt <= 3'h0;
         shift_in <= 8'h00;
         opcode <= 8'h00;
         byte_cnt <= 4'h0;
         have_op <= 1'b0;
      end else if (cs_n) begin
         bit_cnt <= 3'h0;
         byte_cnt <= 4'h0;
         have_op <= 1'b0;
      end else if (sclk_rise) begin
         bit_cnt <= bit_cnt + 3'h1;
         shift_in <= next_byte;
         if (byte_done) begin
            if (!have_op) begin
               opcode <= next_byte;
               have_op <= 1'b1;
            end else if (byte_cnt != 4'hF) begin
               byte_cnt <= byte_cnt + 4'h1;
            end
         end
      end
   end
   // Framing is only clean when deselect lands on a byte edge
   logic aligned;
   assign aligned = (bit_cnt == 3'h0) && have_op;
   // ==========================================
   // Register state
   logic quad_enable, program_paused_flag, erase_paused_flag;
   logic [2:0] security_lock;
   logic [1:0] protect_mode;
   logic program_error_flag, erase_error_flag;
   logic powerup_width_select, pin_function_select;
   logic [1:0] drive_strength;
   logic address_width_status, upper_half_select;
   logic write_latch, reset_armed;
   logic [7:0] data_byte0, data_byte1;
   logic [31:0] addr_acc;
   logic init_pending;
   logic is_4b_op, addr4;
   logic [2:0] need_addr;
   // Data bytes after the opcode captured for status and address use
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         data_byte0 <= 8'h00;
         data_byte1 <= 8'h00;
         addr_acc <= 32'h0000_0000;
      end else if (byte_done && have_op) begin
         if (byte_cnt == 4'h0) begin
            data_byte0 <= next_byte;
         end
         if (byte_cnt == 4'h1) begin
            data_byte1 <= next_byte;
         end
         if (byte_cnt < {1'b0, need_addr}) begin // Data bytes must not push the address out
            addr_acc <= {addr_acc[23:0], next_byte};
         end
      end
   end
   assign is_4b_op = (opcode == sfc_pkg::OP_PP4) || (opcode == sfc_pkg::OP_SE4) ||
      (opcode == sfc_pkg::OP_READ4) || (opcode == sfc_pkg::OP_FREAD4) || (opcode == sfc_pkg::OP_QIOR4);
   assign addr4 = is_4b_op || address_width_status;
   // Write-class commands on a clean deselect
   logic exec, wl_ok;
   assign exec = cs_rise && aligned;
   assign wl_ok = write_latch;
   logic do_wrsr1, do_wrsr2, do_wrsr3, do_pp, do_se;
   assign do_wrsr1 = exec && wl_ok && opcode == sfc_pkg::OP_WRSR1 && byte_cnt >= 4'h2;
   assign do_wrsr2 = exec && wl_ok && opcode == sfc_pkg::OP_WRSR2 && byte_cnt >= 4'h1;
   assign do_wrsr3 = exec && wl_ok && opcode == sfc_pkg::OP_WRSR3 && byte_cnt >= 4'h1;
   logic pp_op, se_op;
   assign pp_op = (opcode == sfc_pkg::OP_PP) || (opcode == sfc_pkg::OP_PP4);
   assign se_op = (opcode == sfc_pkg::OP_SE) || (opcode == sfc_pkg::OP_SE4);
   assign need_addr = addr4 ? sfc_pkg::ADDR_BYTES_4 : sfc_pkg::ADDR_BYTES_3;
   assign do_pp = exec && wl_ok && pp_op && byte_cnt > {1'b0, need_addr};
   assign do_se = exec && wl_ok && se_op && byte_cnt == {1'b0, need_addr};
   logic [7:0] sr2_wr;
   assign sr2_wr = (opcode == sfc_pkg::OP_WRSR1) ? data_byte1 : data_byte0;
   logic [31:0] full_addr;
   // Upper half select fills bit 24 only for three-byte addressing
   assign full_addr = addr4 ? addr_acc : {7'h00, upper_half_select, addr_acc[23:0]};
   // ==========================================
   // Nonvolatile configuration (reset stands for a power cycle)
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         quad_enable <= 1'b0;
         protect_mode <= sfc_pkg::SRP_SOFTWARE;
         security_lock <= 3'h0;
         drive_strength <= sfc_pkg::DRV_RESET;
         powerup_width_select <= 1'b0;
         pin_function_select <= 1'b0;
      end else begin
         if (init_pending && protect_mode == sfc_pkg::SRP_LOCKDOWN) begin
            protect_mode <= sfc_pkg::SRP_SOFTWARE;
         end
         if (do_wrsr1 || do_wrsr2) begin
            quad_enable <= sr2_wr[sfc_pkg::SR2_QE];
            protect_mode[1] <= sr2_wr[sfc_pkg::SR2_PROTECT_MODE_HI];
            security_lock <= security_lock | sr2_wr[sfc_pkg::SR2_LB3:sfc_pkg::SR2_LB1];
         end
         if (do_wrsr1) begin
            protect_mode[0] <= data_byte0[sfc_pkg::SR1_PROTECT_MODE_LO];
         end
         // Read-only and reserved bits of the written byte are dropped
         if (do_wrsr3) begin
            powerup_width_select <= data_byte0[sfc_pkg::SR3_ADP];
            drive_strength <= data_byte0[sfc_pkg::SR3_DRV_HI:sfc_pkg::SR3_DRV_LO];
            pin_function_select <= data_byte0[sfc_pkg::SR3_PINFN];
         end
      end
   end
   // Lock-down recovery runs once after every reset release
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         init_pending <= 1'b1;
      end else begin
         init_pending <= 1'b0;
      end
   end
   // ==========================================
   // Volatile state: address mode, upper half, write latch
   logic do_soft_reset;
   assign do_soft_reset = exec && opcode == sfc_pkg::OP_RST && reset_armed;
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         address_width_status <= 1'b0;
         upper_half_select <= 1'b0;
         reset_armed <= 1'b0;
      end else begin
         if (init_pending || do_soft_reset) begin
            address_width_status <= powerup_width_select;
         end else if (exec && opcode == sfc_pkg::OP_EN4B) begin
            address_width_status <= 1'b1;
         end else if (exec && opcode == sfc_pkg::OP_EX4B) begin
            address_width_status <= 1'b0;
         end
         if (do_soft_reset) begin
            upper_half_select <= 1'b0;
         end else if ((do_pp || do_se) && addr4) begin
            upper_half_select <= addr_acc[24];
         end else if (exec && opcode == sfc_pkg::OP_WREAR && byte_cnt >= 4'h1) begin
            upper_half_select <= data_byte0[sfc_pkg::EAR_A24];
         end
         if (cs_rise) begin
            reset_armed <= aligned && opcode == sfc_pkg::OP_RST_EN;
         end
      end
   end
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         write_latch <= 1'b0;
      end else if (exec && opcode == sfc_pkg::OP_WREN) begin
         write_latch <= 1'b1;
      end else if (do_soft_reset || do_wrsr1 || do_wrsr2 || do_wrsr3 || do_pp || do_se ||
            (exec && opcode == sfc_pkg::OP_WRDI)) begin
         write_latch <= 1'b0;
      end
   end
   // ==========================================
   // Suspend and error flags; hardware set beats the clear
   logic susp_cmd, err_clr;
   assign susp_cmd = exec && opcode == sfc_pkg::OP_SUSP;
   assign err_clr = exec && opcode == sfc_pkg::OP_CLRFLG;
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         erase_paused_flag <= 1'b0;
         program_paused_flag <= 1'b0;
      end else if (susp_cmd) begin
         erase_paused_flag <= erase_paused_flag | busy_erase_in;
         program_paused_flag <= program_paused_flag | busy_program_in;
      end else if ((exec && opcode == sfc_pkg::OP_RESUME) || do_soft_reset) begin
         erase_paused_flag <= 1'b0;
         program_paused_flag <= 1'b0;
      end
   end
   logic prot_hit;
   assign prot_hit = target_protected_in | otp_locked_access_in;
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         program_error_flag <= 1'b0;
         erase_error_flag <= 1'b0;
      end else begin
         if (program_fail_in || (do_pp && prot_hit)) begin
            program_error_flag <= 1'b1;
         end else if (err_clr) begin
            program_error_flag <= 1'b0;
         end
         if (erase_fail_in || (do_se && prot_hit)) begin
            erase_error_flag <= 1'b1;
         end else if (err_clr) begin
            erase_error_flag <= 1'b0;
         end
      end
   end
   // ==========================================
   // Register readback, shifted out on falling serial clock
   logic [7:0] sr2, sr3, ear;
   assign sr2 = {erase_paused_flag, protect_mode[1], security_lock, program_paused_flag,
      quad_enable, address_width_status};
   // Reserved bits read as zero
   assign sr3 = {pin_function_select, drive_strength, powerup_width_select, erase_error_flag,
      program_error_flag, 2'h0};
   assign ear = {7'h00, upper_half_select};
   logic [7:0] rd_val;
   logic rd_op;
   always_comb begin
      rd_op = 1'b1;
      unique case (opcode)
         sfc_pkg::OP_RDSR2: rd_val = sr2;
         sfc_pkg::OP_RDSR3: rd_val = sr3;
         sfc_pkg::OP_RDEAR: rd_val = ear;
         default: begin
            rd_val = 8'h00;
            rd_op = 1'b0;
         end
      endcase
   end
   logic [7:0] shift_out;
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         shift_out <= 8'h00;
         so_out <= 1'b0;
         so_oe_out <= 1'b0;
      end else if (cs_n) begin
         so_oe_out <= 1'b0;
      end else if (sclk_fall && have_op && rd_op) begin
         if (bit_cnt == 3'h0) begin
            so_out <= rd_val[7];
            shift_out <= {rd_val[6:0], 1'b0};
         end else begin
            so_out <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
         end
         so_oe_out <= 1'b1;
      end
   end
   // ==========================================
   // Array commands and configuration outputs
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         program_start_out <= 1'b0;
         erase_start_out <= 1'b0;
         array_addr_out <= 32'h0000_0000;
      end else begin
         program_start_out <= do_pp && !prot_hit;
         erase_start_out <= do_se && !prot_hit;
         if (do_pp || do_se) begin
            array_addr_out <= full_addr;
         end
      end
   end
   assign quad_line_two_en_out = quad_enable;
   assign quad_line_three_en_out = quad_enable;
   assign pause_fn_en_out = !quad_enable && !pin_function_select;
   assign reset_fn_en_out = !quad_enable && pin_function_select;
   assign drive_strength_out = drive_strength;
   assign security_lock_out = security_lock;
   assign protect_mode_out = protect_mode;
   assign write_latch_out = write_latch;
endmodule
`default_nettype wire

// ==== logic/sfc_pkg.sv ====
package sfc_pkg;
   // ==========================================
   // Command opcodes
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR2 = 8'h35;
   localparam logic [7:0] OP_RDSR3 = 8'h15;
   localparam logic [7:0] OP_WRSR1 = 8'h01;
   localparam logic [7:0] OP_WRSR2 = 8'h31;
   localparam logic [7:0] OP_WRSR3 = 8'h11;
   localparam logic [7:0] OP_RDEAR = 8'hC8;
   localparam logic [7:0] OP_WREAR = 8'hC5;
   localparam logic [7:0] OP_SUSP = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7A;
   localparam logic [7:0] OP_RST_EN = 8'h66;
   localparam logic [7:0] OP_RST = 8'h99;
   localparam logic [7:0] OP_CLRFLG = 8'h30;
   localparam logic [7:0] OP_EN4B = 8'hB7;
   localparam logic [7:0] OP_EX4B = 8'hE9;
   localparam logic [7:0] OP_PP = 8'h02;
   localparam logic [7:0] OP_PP4 = 8'h12;
   localparam logic [7:0] OP_SE = 8'h20;
   localparam logic [7:0] OP_SE4 = 8'h21;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_READ4 = 8'h13;
   localparam logic [7:0] OP_FREAD4 = 8'h0C;
   localparam logic [7:0] OP_QIOR4 = 8'hEC;
   // ==========================================
   // Status register 1 protection bit (S7)
   localparam int SR1_PROTECT_MODE_LO = 7;
   // Status register 2 bit positions (S8..S15)
   localparam int SR2_ADS = 0;
   localparam int SR2_QE = 1;
   localparam int SR2_SUS_PGM = 2;
   localparam int SR2_LB1 = 3;
   localparam int SR2_LB3 = 5;
   localparam int SR2_PROTECT_MODE_HI = 6;
   localparam int SR2_SUS_ERS = 7;
   // Status register 3 bit positions (S16..S23)
   localparam int SR3_PE = 2;
   localparam int SR3_EE = 3;
   localparam int SR3_ADP = 4;
   localparam int SR3_DRV_LO = 5;
   localparam int SR3_DRV_HI = 6;
   localparam int SR3_PINFN = 7;
   // Extended address bit
   localparam int EAR_A24 = 0;
   // ==========================================
   // Reset values, protect mode codes and framing constants
   localparam logic [1:0] DRV_RESET = 2'h1;
   localparam logic [1:0] SRP_LOCKDOWN = 2'h2;
   localparam logic [1:0] SRP_SOFTWARE = 2'h0;
   localparam logic [2:0] BIT_CNT_LAST = 3'h7;
   localparam logic [2:0] ADDR_BYTES_3 = 3'h3;
   localparam logic [2:0] ADDR_BYTES_4 = 3'h4;
endpackage

// ==== verification/sfc_ctrl_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port checks of the flash control block
module sfc_ctrl_properties (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Serial side
   input wire logic cs_n_in,
   input wire logic so_oe_out,
   // Configuration and results
   input wire logic quad_line_two_en_out,
   input wire logic quad_line_three_en_out,
   input wire logic pause_fn_en_out,
   input wire logic reset_fn_en_out,
   input wire logic [2:0] security_lock_out,
   input wire logic program_start_out,
   input wire logic erase_start_out,
   input wire logic write_latch_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   // ==========================================
   // Assertions and covers
   a_quad_lines_pair: assert property (quad_line_two_en_out == quad_line_three_en_out)
      else $error("quad line enables differ");
   a_quad_kills_pins: assert property (quad_line_two_en_out |-> !pause_fn_en_out && !reset_fn_en_out)
      else $error("pin function enabled in quad mode");
   a_pin_fn_excl: assert property (!(pause_fn_en_out && reset_fn_en_out))
      else $error("pause and reset both enabled");
   a_lock_never_clear: assert property ((security_lock_out & $past(security_lock_out)) == $past(security_lock_out))
      else $error("lock bit cleared");
   // The latch only moves once the frame has closed
   a_latch_on_deselect: assert property ($rose(write_latch_out) |-> $past(cs_n_in) && $past(cs_n_in, 2))
      else $error("latch set inside a frame");
   a_start_one_pulse: assert property (program_start_out || erase_start_out |=> !program_start_out && !erase_start_out)
      else $error("start pulse too long");
   a_program_drops_latch: assert property (program_start_out |-> !write_latch_out)
      else $error("latch kept after program");
   a_oe_idle_off: assert property (cs_n_in [*6] |-> !so_oe_out)
      else $error("output driven while deselected");
   c_program: cover property (program_start_out);
   c_erase: cover property (erase_start_out);
   c_quad: cover property ($rose(quad_line_two_en_out));
endmodule
bind sfc_ctrl sfc_ctrl_properties i_sfc_ctrl_properties (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .cs_n_in(cs_n_in), .so_oe_out(so_oe_out), .quad_line_two_en_out(quad_line_two_en_out),
   .quad_line_three_en_out(quad_line_three_en_out), .pause_fn_en_out(pause_fn_en_out),
   .reset_fn_en_out(reset_fn_en_out), .security_lock_out(security_lock_out),
   .program_start_out(program_start_out), .erase_start_out(erase_start_out), .write_latch_out(write_latch_out));
`default_nettype wire

// ==== verification/sfc_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Host controller: mode 0, serial clock one tenth of the system clock
module sfc_host_model (
   // System clock
   input wire logic clk_in,
   // Serial pins
   output logic cs_n_out,
   output logic sclk_out,
   output logic si_out,
   input wire logic so_in
);
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      si_out = 1'b0;
   end
   // Frame of nbits, command byte first; rx keeps the last eight bits read
   task automatic frame(input logic [63:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      @(negedge clk_in) cs_n_out = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         si_out = tx[63 - i];
         repeat (5) @(negedge clk_in);
         rx = {rx[6:0], so_in};
         sclk_out = 1'b1;
         repeat (5) @(negedge clk_in);
         sclk_out = 1'b0;
      end
      repeat (5) @(negedge clk_in);
      cs_n_out = 1'b1;
      // Released data line must not look like held data
      si_out = ~si_out;
      repeat (10) @(negedge clk_in);
   endtask
endmodule
`default_nettype wire

// ==== verification/test_serial_flash_status_addr_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_serial_flash_status_addr_ctrl;
   // ==========================================
   // Clock, reset, wiring
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic busy_erase = 1'b0;
   logic busy_program = 1'b0;
   logic program_fail = 1'b0;
   logic erase_fail = 1'b0;
   logic prot = 1'b0;
   logic otp = 1'b0;
   wire logic cs_n, sclk, si, so, so_oe, quad_two, quad_three, pause_en, reset_en, latch, pp_start, er_start;
   wire logic [1:0] drive, protect;
   wire logic [2:0] lock;
   wire logic [31:0] addr;
   logic [7:0] v;
   logic [31:0] pp_addr = 32'h0000_0000;
   int bad_count = 0;
   int cmp_count = 0;
   int pp_cnt = 0;
   int er_cnt = 0;
   always #2 clk_in = ~clk_in;
   sfc_ctrl i_sfc_ctrl (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n), .sclk_in(sclk), .si_in(si),
      .so_out(so), .so_oe_out(so_oe), .busy_erase_in(busy_erase), .busy_program_in(busy_program),
      .program_fail_in(program_fail), .erase_fail_in(erase_fail), .target_protected_in(prot),
      .otp_locked_access_in(otp), .quad_line_two_en_out(quad_two), .quad_line_three_en_out(quad_three),
      .pause_fn_en_out(pause_en), .reset_fn_en_out(reset_en), .drive_strength_out(drive),
      .security_lock_out(lock), .protect_mode_out(protect), .program_start_out(pp_start),
      .erase_start_out(er_start), .array_addr_out(addr), .write_latch_out(latch));
   sfc_host_model i_host (.clk_in(clk_in), .cs_n_out(cs_n), .sclk_out(sclk), .si_out(si), .so_in(so));
   // Start pulses last one cycle; counted at the falling edge, where they are settled
   always @(negedge clk_in) begin
      if (pp_start === 1'b1) begin
         pp_cnt++;
         pp_addr = addr;
      end
      if (er_start === 1'b1) er_cnt++;
   end
   // ==========================================
   // Compare and access tasks
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_port(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] op);
      i_host.frame({op, 56'h0}, 8, v);
   endtask
   task automatic wr(input logic [7:0] op, input logic [7:0] d);
      i_host.frame({op, d, 48'h0}, 16, v);
   endtask
   task automatic rd(input logic [7:0] op, input logic [7:0] exp);
      i_host.frame({op, 56'h0}, 16, v);
      chk_reg(v, exp);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // A full run takes far less than this span
   initial begin
      #200000;
      bad_count++;
      tally_and_finish();
   end
   // ==========================================
   // Test sequence
   initial begin
      repeat (10) @(negedge clk_in);
      sys_rst_in = 1'b0;
      repeat (4) @(negedge clk_in);
      rd(sfc_pkg::OP_RDSR2, 8'h00);
      chk_port({31'h0, so_oe}, 32'h0000_0000);
      rd(sfc_pkg::OP_RDSR3, 8'h20);
      chk_port({30'h0, pause_en, quad_two}, 32'h0000_0002);
      wr(sfc_pkg::OP_WRSR2, 8'h02);
      rd(sfc_pkg::OP_RDSR2, 8'h00);
      cmd(sfc_pkg::OP_WREN);
      chk_port({31'h0, latch}, 32'h0000_0001);
      cmd(sfc_pkg::OP_WRDI);
      chk_port({31'h0, latch}, 32'h0000_0000);
      cmd(sfc_pkg::OP_WREN);
      i_host.frame({sfc_pkg::OP_WRSR2, 8'h02, 48'h0}, 12, v);
      rd(sfc_pkg::OP_RDSR2, 8'h00);
      wr(sfc_pkg::OP_WRSR2, 8'h0A);
      rd(sfc_pkg::OP_RDSR2, 8'h0A);
      chk_port({24'h0, quad_two, quad_three, pause_en, reset_en, lock, latch}, 32'h0000_00C2);
      cmd(sfc_pkg::OP_WREN);
      wr(sfc_pkg::OP_WRSR2, 8'h00);
      rd(sfc_pkg::OP_RDSR2, 8'h08);
      // Every drive code; reserved bits of the write stay zero
      for (int d = 0; d < 4; d++) begin
         cmd(sfc_pkg::OP_WREN);
         wr(sfc_pkg::OP_WRSR3, {d[1], d[1:0], 5'h00});
         rd(sfc_pkg::OP_RDSR3, {d[1], d[1:0], 5'h00});
         chk_port({27'h0, drive, pause_en, reset_en, quad_two}, {27'h0, d[1:0], ~d[1], d[1], 1'b0});
      end
      @(negedge clk_in) program_fail = 1'b1;
      @(negedge clk_in) program_fail = 1'b0;
      rd(sfc_pkg::OP_RDSR3, 8'hE4);
      @(negedge clk_in) erase_fail = 1'b1;
      @(negedge clk_in) erase_fail = 1'b0;
      rd(sfc_pkg::OP_RDSR3, 8'hEC);
      cmd(sfc_pkg::OP_CLRFLG);
      rd(sfc_pkg::OP_RDSR3, 8'hE0);
      busy_erase = 1'b1;
      cmd(sfc_pkg::OP_SUSP);
      busy_erase = 1'b0;
      rd(sfc_pkg::OP_RDSR2, 8'h88);
      cmd(sfc_pkg::OP_RESUME);
      rd(sfc_pkg::OP_RDSR2, 8'h08);
      busy_program = 1'b1;
      cmd(sfc_pkg::OP_SUSP);
      busy_program = 1'b0;
      rd(sfc_pkg::OP_RDSR2, 8'h0C);
      cmd(sfc_pkg::OP_RST_EN);
      cmd(sfc_pkg::OP_RST);
      rd(sfc_pkg::OP_RDSR2, 8'h08);
      cmd(sfc_pkg::OP_WREN);
      wr(sfc_pkg::OP_WREAR, 8'hFF);
      rd(sfc_pkg::OP_RDEAR, 8'h01);
      cmd(sfc_pkg::OP_WREN);
      i_host.frame({sfc_pkg::OP_PP, 24'h12_3456, 8'hA5, 24'h0}, 40, v);
      chk_port(pp_addr, 32'h0112_3456);
      cmd(sfc_pkg::OP_WREN);
      i_host.frame({sfc_pkg::OP_PP, 24'h00_0000, 8'hA5, 24'h0}, 36, v);
      chk_port({pp_cnt[30:0], latch}, 32'h0000_0003);
      i_host.frame({sfc_pkg::OP_PP4, 32'h00AB_CDEF, 8'h5A, 16'h0}, 48, v);
      chk_port(pp_addr, 32'h00AB_CDEF);
      cmd(sfc_pkg::OP_WREN);
      i_host.frame({sfc_pkg::OP_SE, 24'h00_1000, 32'h0}, 32, v);
      chk_port(er_cnt, 32'h0000_0001);
      // Protected targets start no command; they raise the error flag and drop the latch
      prot = 1'b1;
      cmd(sfc_pkg::OP_WREN);
      i_host.frame({sfc_pkg::OP_SE4, 32'h0000_2000, 24'h0}, 40, v);
      prot = 1'b0;
      otp = 1'b1;
      cmd(sfc_pkg::OP_WREN);
      i_host.frame({sfc_pkg::OP_PP, 24'h00_0100, 8'h5A, 24'h0}, 40, v);
      otp = 1'b0;
      chk_port({er_cnt[15:0], pp_cnt[15:0]}, 32'h0001_0002);
      rd(sfc_pkg::OP_RDSR3, 8'hEC);
      cmd(sfc_pkg::OP_CLRFLG);
      cmd(sfc_pkg::OP_WREN);
      wr(sfc_pkg::OP_WRSR3, 8'hF0);
      cmd(sfc_pkg::OP_EN4B);
      rd(sfc_pkg::OP_RDSR2, 8'h09);
      cmd(sfc_pkg::OP_WREN);
      i_host.frame({sfc_pkg::OP_PP, 32'h0134_5678, 8'h11, 16'h0}, 48, v);
      chk_port(pp_addr, 32'h0134_5678);
      rd(sfc_pkg::OP_RDEAR, 8'h01);
      cmd(sfc_pkg::OP_EX4B);
      rd(sfc_pkg::OP_RDSR2, 8'h08);
      cmd(sfc_pkg::OP_RST_EN);
      cmd(sfc_pkg::OP_RST);
      rd(sfc_pkg::OP_RDSR2, 8'h09);
      cmd(sfc_pkg::OP_WREN);
      i_host.frame({sfc_pkg::OP_WRSR1, 8'h00, 8'h48, 40'h0}, 24, v);
      chk_port({30'h0, protect}, 32'h0000_0002);
      sys_rst_in = 1'b1;
      repeat (10) @(negedge clk_in);
      sys_rst_in = 1'b0;
      repeat (4) @(negedge clk_in);
      chk_port({30'h0, protect}, 32'h0000_0000);
      tally_and_finish();
   end
endmodule
`default_nettype wire
